// ==== mct_pkg.sv ====
/*
 * Shared constants and types for the five-channel timer common control.
 * Assumes an 8-bit address, 16-bit data register port and one 100 MHz clock.
 */
package mct_pkg;
    // ==========================================================
    // Geometry
    localparam int NCH     = 5;
    localparam int AW      = 8;
    localparam int DW      = 16;
    localparam int CH_QUAD = 2;
    localparam int NSTAT   = 6;

    // ==========================================================
    // Register offsets
    localparam logic [AW-1:0] OFS_RUN    = 8'h00;
    localparam logic [AW-1:0] OFS_SYNC   = 8'h01;
    localparam logic [AW-1:0] OFS_MODE   = 8'h02;
    localparam logic [AW-1:0] OFS_COMB   = 8'h03;
    localparam logic [AW-1:0] OFS_STAT   = 8'h04;
    localparam logic [AW-1:0] OFS_CLR    = 8'h05;
    localparam logic [AW-1:0] OFS_IEN    = 8'h06;
    localparam logic [AW-1:0] OFS_CLRSEL = 8'h07;
    localparam logic [AW-1:0] OFS_CNT    = 8'h10;
    localparam logic [AW-1:0] OFS_CMPA   = 8'h18;
    localparam logic [AW-1:0] OFS_CMPB   = 8'h20;

    // ==========================================================
    // Reset values and fixed-one masks
    localparam logic [7:0] RUN_RST  = 8'he0;
    localparam logic [7:0] SYNC_RST = 8'he0;
    localparam logic [7:0] MODE_RST = 8'h80;
    localparam logic [7:0] COMB_RST = 8'hc0;
    localparam logic [7:0] RUN_ONES  = 8'he0;
    localparam logic [7:0] SYNC_ONES = 8'he0;
    localparam logic [7:0] MODE_ONES = 8'h80;
    localparam logic [7:0] COMB_ONES = 8'hc0;

    // ==========================================================
    // Field positions
    localparam int MODE_QUAD_BIT = 6;
    localparam int MODE_WRAP_BIT = 5;
    localparam int COMB_LO_BIT   = 4;
    localparam int STAT_WRAP_BIT = 5;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        MCT_NORM_A = 2'b00,
        MCT_NORM_B = 2'b01,
        MCT_COMPL  = 2'b10,
        MCT_RSYNC  = 2'b11
    } mct_comb_t;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } mct_bus_req_t;
endpackage

// ==== mct_quad.sv ====
/*
 * Quadrature edge decoder: one up or down pulse per edge of one phase; edges on both phases in one cycle give none.
 * Assumes both phase inputs are already synchronous to clk_i.
 */
`timescale 1ns/10ps
module mct_quad (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Phase inputs
    input  wire logic phase_input_a_i,
    input  wire logic phase_input_b_i,
    // Step pulses
    output logic      up_o,
    output logic      dn_o
);
    logic a_r;
    logic b_r;
    logic a_rise, a_fall, b_rise, b_fall;

    // ==========================================================
    // Previous levels track the pins even in reset, so no false edge follows it
    always_ff @(posedge clk_i) begin
        a_r <= phase_input_a_i;
        b_r <= phase_input_b_i;
    end

    // Edge detection
    assign a_rise = phase_input_a_i & ~a_r;
    assign a_fall = ~phase_input_a_i & a_r;
    assign b_rise = phase_input_b_i & ~b_r;
    assign b_fall = ~phase_input_b_i & b_r;

    // Direction table; a double edge is ambiguous, and nothing counts in reset
    always_comb begin
        dn_o = (a_rise & ~b_r) | (b_rise & a_r) | (a_fall & b_r) | (b_fall & ~a_r);
        up_o = (a_rise & b_r) | (b_rise & ~a_r) | (a_fall & ~b_r) | (b_fall & a_r);
        if (rst_i || (up_o && dn_o)) begin
            up_o = 1'b0;
            dn_o = 1'b0;
        end
    end
endmodule

// ==== mct_pwm.sv ====
/*
 * One pulse-width output: set on compare A, cleared on compare B.
 * Assumes match strobes are single-cycle pulses from the counter logic.
 */
`timescale 1ns/10ps
module mct_pwm (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Control
    input  wire logic en_i,
    input  wire logic match_a_i,
    input  wire logic match_b_i,
    // Pin
    output logic      pulse_o,
    output logic      pulse_oe_o
);
    // ==========================================================
    // Output level; B wins when both match, ending the pulse
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            pulse_o <= 1'b0;
        end else if (match_b_i) begin
            pulse_o <= 1'b0;
        end else if (match_a_i) begin
            pulse_o <= 1'b1;
        end
    end

    // Pin drive follows the mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_oe_o <= 1'b0;
        end else begin
            pulse_oe_o <= en_i;
        end
    end
endmodule

// ==== mct_ctrl.sv ====
/*
 * Common control of a five-channel timer: run, lockstep and mode registers,
 * the channel counters, compare registers, quadrature counting on channel 2,
 * pulse outputs and a masked interrupt.
 * Assumes synchronous inputs, one clock, and a master that never overlaps strobes.
 */
// What this block does
// - Run bits 0-4 start or halt counters.
// - Run register resets to e0.
// - Top three run and lockstep bits read one.
// - Lockstep channels preset and clear together.
// - Independent channels ignore other channels' events.
// - Lockstep register resets to e0.
// - Mode register resets 80, bit 7 one.
// - Mode bit 6 makes channel 2 quadrature.
// - Quadrature counts every single-phase edge, direction by table.
// - Quadrature ignores tick and edge selection.
// - Channel 2 clear and flags stay active.
// - Mode bit 5 picks wrap flag condition.
// - Mode bits 0-4 enable pulse outputs.
// - Compare A sets, compare B clears output.
// - Combination mode overrides channel 3,4 pulse bits.
// - Field 00/01 normal, 10 complementary, 11 reset-sync; 10 and 11 only switch channel 3,4 pulse outputs off.
`timescale 1ns/10ps
module mct_ctrl #(
    parameter int CW       = 16,
    parameter int PRESCALE = 4
) (
    // Clock, reset, standby
    input  wire logic                          clk_i,
    input  wire logic                          rst_b_i,
    input  wire logic                          standby_i,
    // Register port
    input  wire mct_pkg::mct_bus_req_t         bus_req_i,
    output logic [mct_pkg::DW-1:0]             rdata_o,
    // Quadrature encoder
    input  wire logic                          phase_input_a_i,
    input  wire logic                          phase_input_b_i,
    // Pulse outputs
    output logic [mct_pkg::NCH-1:0]            pulse_output_o,
    output logic [mct_pkg::NCH-1:0]            pulse_output_oe_o,
    // Interrupt
    output logic                               irq_o
);
    localparam int NCH = mct_pkg::NCH;
    localparam int DVW = $clog2(PRESCALE + 1);
    localparam int NSTAT_W = mct_pkg::NSTAT;

    // ==========================================================
    // Elaboration checks
    if (CW < 2 || CW > mct_pkg::DW) begin : g_bad_cw
        $error("CW must lie between 2 and the data width");
    end
    if (PRESCALE < 1) begin : g_bad_pre
        $error("PRESCALE must be at least one");
    end

    // ==========================================================
    // Declarations
    logic                    rst_w;
    logic [7:0]              run_r;
    logic [7:0]              sync_r;
    logic [7:0]              mode_r;
    logic [7:0]              comb_r;
    logic [NCH-1:0]          clrsel_r;
    logic [NSTAT_W-1:0]      ien_r;
    logic [NSTAT_W-1:0]      stat_r;
    logic [CW-1:0]           cnt_r  [NCH];
    logic [CW-1:0]           cmpa_r [NCH];
    logic [CW-1:0]           cmpb_r [NCH];
    logic [NCH-1:0]          adv_r;
    logic [DVW-1:0]          div_r;
    logic                    tick_r;
    logic [NCH-1:0]          cnt_wr_w;
    logic [NCH-1:0]          cmpa_wr_w;
    logic [NCH-1:0]          cmpb_wr_w;
    logic [NCH-1:0]          preset_w;
    logic [NCH-1:0]          clear_w;
    logic [NCH-1:0]          up_w;
    logic [NCH-1:0]          dn_w;
    logic [NCH-1:0]          match_a_w;
    logic [NCH-1:0]          match_b_w;
    logic [NCH-1:0]          clr_evt_w;
    logic [NCH-1:0]          pwm_en_w;
    logic                    quad_on_w;
    logic                    q_up_w;
    logic                    q_dn_w;
    logic                    ovf_w;
    logic                    udf_w;
    logic                    wrap_set_w;
    logic [NSTAT_W-1:0]      stat_set_w;
    logic [NSTAT_W-1:0]      stat_clr_w;
    mct_pkg::mct_comb_t      comb_w;
    logic [mct_pkg::AW-1:0]  idx_cnt_w;
    logic [mct_pkg::AW-1:0]  idx_cmpa_w;
    logic [mct_pkg::AW-1:0]  idx_cmpb_w;

    // Standby acts exactly like reset on every register
    assign rst_w = !rst_b_i || standby_i;

    // ==========================================================
    // Address decode for the per-channel words
    assign idx_cnt_w  = bus_req_i.addr - mct_pkg::OFS_CNT;
    assign idx_cmpa_w = bus_req_i.addr - mct_pkg::OFS_CMPA;
    assign idx_cmpb_w = bus_req_i.addr - mct_pkg::OFS_CMPB;

    for (genvar k = 0; k < NCH; k++) begin : g_dec
        assign cnt_wr_w[k]  = bus_req_i.wr && (idx_cnt_w == mct_pkg::AW'(k));
        assign cmpa_wr_w[k] = bus_req_i.wr && (idx_cmpa_w == mct_pkg::AW'(k));
        assign cmpb_wr_w[k] = bus_req_i.wr && (idx_cmpb_w == mct_pkg::AW'(k));
    end

    // ==========================================================
    // Control registers; reserved bits are forced to one on write
    always_ff @(posedge clk_i) begin
        if (rst_w) begin
            run_r    <= mct_pkg::RUN_RST;
            sync_r   <= mct_pkg::SYNC_RST;
            mode_r   <= mct_pkg::MODE_RST;
            comb_r   <= mct_pkg::COMB_RST;
            clrsel_r <= '0;
            ien_r    <= '0;
        end else if (bus_req_i.wr) begin
            unique case (bus_req_i.addr)
                mct_pkg::OFS_RUN:    run_r    <= bus_req_i.wdata[7:0] | mct_pkg::RUN_ONES;
                mct_pkg::OFS_SYNC:   sync_r   <= bus_req_i.wdata[7:0] | mct_pkg::SYNC_ONES;
                mct_pkg::OFS_MODE:   mode_r   <= bus_req_i.wdata[7:0] | mct_pkg::MODE_ONES;
                mct_pkg::OFS_COMB:   comb_r   <= bus_req_i.wdata[7:0] | mct_pkg::COMB_ONES;
                mct_pkg::OFS_IEN:    ien_r    <= bus_req_i.wdata[NSTAT_W-1:0];
                mct_pkg::OFS_CLRSEL: clrsel_r <= bus_req_i.wdata[NCH-1:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Prescaler: one tick every PRESCALE clocks
    always_ff @(posedge clk_i) begin
        if (rst_w || div_r == DVW'(PRESCALE - 1)) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_w) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= (div_r == DVW'(PRESCALE - 1));
        end
    end

    // ==========================================================
    // Quadrature decoder for channel 2
    mct_quad u_quad (
        .clk_i           (clk_i),
        .rst_i           (rst_w),
        .phase_input_a_i (phase_input_a_i),
        .phase_input_b_i (phase_input_b_i),
        .up_o            (q_up_w),
        .dn_o            (q_dn_w)
    );

    assign quad_on_w = mode_r[mct_pkg::MODE_QUAD_BIT];
    assign comb_w    = mct_pkg::mct_comb_t'(comb_r[mct_pkg::COMB_LO_BIT +: 2]);

    // ==========================================================
    // Per-channel counters, compares and pulse outputs
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic preset_l;
        logic clear_l;

        // Lockstep fan-in: own event, or any event of a fellow lockstep channel
        always_comb begin
            preset_l = 1'b0;
            clear_l  = 1'b0;
            for (int j = 0; j < NCH; j++) begin
                if (cnt_wr_w[j] && (j == i || (sync_r[i] && sync_r[j]))) begin
                    preset_l = 1'b1;
                end
                if (clr_evt_w[j] && (j == i || (sync_r[i] && sync_r[j]))) begin
                    clear_l = 1'b1;
                end
            end
        end
        assign preset_w[i] = preset_l;
        assign clear_w[i]  = clear_l;

        // Channel 2 in quadrature takes only encoder steps, never the tick
        if (i == mct_pkg::CH_QUAD) begin : g_q
            assign up_w[i] = run_r[i] && (quad_on_w ? q_up_w : tick_r);
            assign dn_w[i] = run_r[i] && quad_on_w && q_dn_w;
        end else begin : g_n
            assign up_w[i] = run_r[i] && tick_r;
            assign dn_w[i] = 1'b0;
        end

        // Software preset beats clear, clear beats counting
        always_ff @(posedge clk_i) begin
            if (rst_w) begin
                cnt_r[i] <= '0;
            end else if (preset_w[i]) begin
                cnt_r[i] <= bus_req_i.wdata[CW-1:0];
            end else if (clear_w[i]) begin
                cnt_r[i] <= '0;
            end else if (up_w[i]) begin
                cnt_r[i] <= cnt_r[i] + 1'b1;
            end else if (dn_w[i]) begin
                cnt_r[i] <= cnt_r[i] - 1'b1;
            end
        end

        // Compare only right after a real count step, so a halted counter stays quiet
        always_ff @(posedge clk_i) begin
            if (rst_w) begin
                adv_r[i] <= 1'b0;
            end else begin
                adv_r[i] <= !preset_w[i] && !clear_w[i] && (up_w[i] || dn_w[i]);
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_w) begin
                cmpa_r[i] <= '1;
                cmpb_r[i] <= '1;
            end else begin
                if (cmpa_wr_w[i]) begin
                    cmpa_r[i] <= bus_req_i.wdata[CW-1:0];
                end
                if (cmpb_wr_w[i]) begin
                    cmpb_r[i] <= bus_req_i.wdata[CW-1:0];
                end
            end
        end

        assign match_a_w[i] = adv_r[i] && (cnt_r[i] == cmpa_r[i]);
        assign match_b_w[i] = adv_r[i] && (cnt_r[i] == cmpb_r[i]);
        // Clear source stays live in quadrature mode too
        assign clr_evt_w[i] = match_a_w[i] && clrsel_r[i];

        // Channels 3 and 4 yield to a combination mode
        if (i >= 3) begin : g_cmb
            assign pwm_en_w[i] = mode_r[i] && !comb_w[1];
        end else begin : g_pl
            assign pwm_en_w[i] = mode_r[i];
        end

        mct_pwm u_pwm (
            .clk_i      (clk_i),
            .rst_i      (rst_w),
            .en_i       (pwm_en_w[i]),
            .match_a_i  (match_a_w[i]),
            .match_b_i  (match_b_w[i]),
            .pulse_o    (pulse_output_o[i]),
            .pulse_oe_o (pulse_output_oe_o[i])
        );
    end

    // ==========================================================
    // Channel 2 wrap flag condition
    assign ovf_w = up_w[mct_pkg::CH_QUAD] && !preset_w[mct_pkg::CH_QUAD] && !clear_w[mct_pkg::CH_QUAD]
                   && (cnt_r[mct_pkg::CH_QUAD] == '1);
    assign udf_w = dn_w[mct_pkg::CH_QUAD] && !preset_w[mct_pkg::CH_QUAD] && !clear_w[mct_pkg::CH_QUAD]
                   && (cnt_r[mct_pkg::CH_QUAD] == '0);
    assign wrap_set_w = ovf_w || (udf_w && !mode_r[mct_pkg::MODE_WRAP_BIT]);

    // ==========================================================
    // Sticky status; a new event wins over a clear in the same cycle
    assign stat_set_w = {wrap_set_w, match_a_w};
    assign stat_clr_w = (bus_req_i.wr && bus_req_i.addr == mct_pkg::OFS_CLR) ?
                        bus_req_i.wdata[NSTAT_W-1:0] : '0;

    always_ff @(posedge clk_i) begin
        if (rst_w) begin
            stat_r <= '0;
        end else begin
            stat_r <= (stat_r & ~stat_clr_w) | stat_set_w;
        end
    end

    assign irq_o = |(stat_r & ien_r);

    // ==========================================================
    // Read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_w || !bus_req_i.rd) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= '0;
            unique case (bus_req_i.addr)
                mct_pkg::OFS_RUN:    rdata_o[7:0]         <= run_r;
                mct_pkg::OFS_SYNC:   rdata_o[7:0]         <= sync_r;
                mct_pkg::OFS_MODE:   rdata_o[7:0]         <= mode_r;
                mct_pkg::OFS_COMB:   rdata_o[7:0]         <= comb_r;
                mct_pkg::OFS_STAT:   rdata_o[NSTAT_W-1:0] <= stat_r;
                mct_pkg::OFS_IEN:    rdata_o[NSTAT_W-1:0] <= ien_r;
                mct_pkg::OFS_CLRSEL: rdata_o[NCH-1:0]     <= clrsel_r;
                default: begin
                    for (int k = 0; k < NCH; k++) begin
                        if (idx_cnt_w == mct_pkg::AW'(k)) begin
                            rdata_o <= mct_pkg::DW'(cnt_r[k]);
                        end
                        if (idx_cmpa_w == mct_pkg::AW'(k)) begin
                            rdata_o <= mct_pkg::DW'(cmpa_r[k]);
                        end
                        if (idx_cmpb_w == mct_pkg::AW'(k)) begin
                            rdata_o <= mct_pkg::DW'(cmpb_r[k]);
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Assertions
    a_run_reset_val: assert property (@(posedge clk_i)
        (!rst_b_i || standby_i) |=> (run_r == mct_pkg::RUN_RST && sync_r == mct_pkg::SYNC_RST))
        else $error("run or lockstep register not at reset value");

    a_fixed_ones: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        bus_req_i.wr |=> (run_r[7:5] == 3'b111 && sync_r[7:5] == 3'b111 && mode_r[7]))
        else $error("reserved bits lost their ones");

    a_halt_holds: assert property (@(posedge clk_i) disable iff (rst_w)
        (!run_r[0] && !preset_w[0] && !clear_w[0]) |=> $stable(cnt_r[0]))
        else $error("halted counter moved");

    a_run_counts: assert property (@(posedge clk_i) disable iff (rst_w)
        (run_r[0] && tick_r && !preset_w[0] && !clear_w[0]) |=> (cnt_r[0] == CW'($past(cnt_r[0]) + 1'b1)))
        else $error("running counter did not step on tick");

    a_sync_preset: assert property (@(posedge clk_i) disable iff (rst_w)
        (cnt_wr_w[0] && sync_r[0] && sync_r[1]) |=> (cnt_r[1] == $past(bus_req_i.wdata[CW-1:0])))
        else $error("lockstep preset not shared");

    a_indep_chan: assert property (@(posedge clk_i) disable iff (rst_w)
        (cnt_wr_w[0] && !sync_r[1] && !run_r[1] && !clr_evt_w[1]) |=> $stable(cnt_r[1]))
        else $error("independent channel disturbed");

    a_quad_down: assert property (@(posedge clk_i) disable iff (rst_w)
        (quad_on_w && run_r[2] && dn_w[2] && !preset_w[2] && !clear_w[2])
        |=> (cnt_r[2] == CW'($past(cnt_r[2]) - 1'b1)))
        else $error("quadrature down step missed");

    a_quad_no_tick: assert property (@(posedge clk_i) disable iff (rst_w)
        (quad_on_w && tick_r && !q_up_w && !q_dn_w && !preset_w[2] && !clear_w[2]) |=> $stable(cnt_r[2]))
        else $error("tick moved channel 2 in quadrature mode");

    a_wrap_ovf_only: assert property (@(posedge clk_i) disable iff (rst_w)
        (mode_r[mct_pkg::MODE_WRAP_BIT] && udf_w && !ovf_w && !stat_r[mct_pkg::STAT_WRAP_BIT])
        |=> !stat_r[mct_pkg::STAT_WRAP_BIT])
        else $error("underflow set wrap flag in overflow-only mode");

    a_pwm_set: assert property (@(posedge clk_i) disable iff (rst_w)
        (pwm_en_w[0] && match_a_w[0] && !match_b_w[0]) |=> pulse_output_o[0])
        else $error("pulse did not rise on compare A");

    a_comb_override: assert property (@(posedge clk_i) disable iff (rst_w)
        (comb_w == mct_pkg::MCT_COMPL || comb_w == mct_pkg::MCT_RSYNC) |=> !pulse_output_oe_o[3])
        else $error("pulse bit not overridden by combination mode");
endmodule

// ==== mct_enc_model.sv ====
/*
 * Quadrature encoder model driving the two phase pins of the timer.
 * Assumes the bench calls step() from its main sequence, one call at a time.
 */
`timescale 1ns/10ps
module mct_enc_model (
    // Clock
    input  wire logic clk_i,
    // Phase pins
    output logic      phase_input_a_o,
    output logic      phase_input_b_o
);
    // ==========================================================
    // Gray position: only one phase moves per step, never both at once
    logic [1:0] pos = 2'h0;
    assign phase_input_a_o = pos[1];
    assign phase_input_b_o = pos[1] ^ pos[0];

    // One edge forward (B leads A) or back, then a short idle gap
    task automatic step(input logic up);
        @(posedge clk_i);
        pos <= up ? pos + 2'h1 : pos - 2'h1;
        repeat (3) @(posedge clk_i);
    endtask
endmodule

// ==== mct_ctrl_tb.sv ====
/*
 * Self-checking bench for the timer common control, register port driven.
 * Assumes the design package and the encoder model are compiled first.
 */
`timescale 1ns/10ps
module mct_ctrl_tb;
    // ==========================================================
    // Signals
    logic                  clk_i = 1'b0;
    logic                  rst_b_i = 1'b0;
    logic                  standby_i = 1'b0;
    mct_pkg::mct_bus_req_t req = '0;
    logic [15:0]           rdata;
    logic                  pha, phb, irq;
    logic [4:0]            pulse, oe;
    logic [15:0]           d;
    int                    miscompares = 0;
    int                    tests_run = 0;

    mct_ctrl #(.CW(16), .PRESCALE(4)) DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .standby_i(standby_i),
        .bus_req_i(req), .rdata_o(rdata), .phase_input_a_i(pha), .phase_input_b_i(phb),
        .pulse_output_o(pulse), .pulse_output_oe_o(oe), .irq_o(irq));
    mct_enc_model ENC (.clk_i(clk_i), .phase_input_a_o(pha), .phase_input_b_o(phb));

    // ==========================================================
    // Clock, verdict and watchdog
    initial forever #5 clk_i = ~clk_i;

    task automatic finish_test;
        if (miscompares == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Whole run is a few hundred cycles; this is far beyond it
    initial begin
        #200us;
        miscompares++;
        finish_test;
    end

    // ==========================================================
    // Bus tasks and compare
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] v);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        req <= '0;
        @(posedge clk_i);
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [15:0] v);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        req <= '0;
        #1 v = rdata;
        @(posedge clk_i);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] v;
        reg_rd(a, v);
        chk(v, exp);
    endtask

    // Bounded wait for a pulse pin level
    task automatic wait_pulse(input logic lvl);
        int n;
        n = 0;
        while (pulse[0] !== lvl && n < 60) begin
            @(posedge clk_i);
            n++;
        end
        chk({15'h0, pulse[0]}, {15'h0, lvl});
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        rd_chk(mct_pkg::OFS_RUN, 16'h00e0);
        rd_chk(mct_pkg::OFS_SYNC, 16'h00e0);
        rd_chk(mct_pkg::OFS_MODE, 16'h0080);
        rd_chk(8'h3f, 16'h0000);
        reg_wr(mct_pkg::OFS_RUN, 16'h0000);
        rd_chk(mct_pkg::OFS_RUN, 16'h00e0);
        reg_wr(mct_pkg::OFS_SYNC, 16'h001f);
        rd_chk(mct_pkg::OFS_SYNC, 16'h00ff);
        // Lockstep preset reaches fellows only
        reg_wr(mct_pkg::OFS_SYNC, 16'h0003);
        reg_wr(mct_pkg::OFS_CNT, 16'h0055);
        rd_chk(mct_pkg::OFS_CNT + 8'h01, 16'h0055);
        rd_chk(mct_pkg::OFS_CNT + 8'h02, 16'h0000);
        repeat (20) @(posedge clk_i);
        rd_chk(mct_pkg::OFS_CNT, 16'h0055);
        reg_wr(mct_pkg::OFS_RUN, 16'h0001);
        repeat (20) @(posedge clk_i);
        reg_wr(mct_pkg::OFS_RUN, 16'h0000);
        reg_rd(mct_pkg::OFS_CNT, d);
        chk({15'h0, d > 16'h0055}, 16'h0001);
        rd_chk(mct_pkg::OFS_CNT + 8'h01, 16'h0055);
        // Quadrature counting on channel 2
        reg_wr(mct_pkg::OFS_SYNC, 16'h0000);
        reg_wr(mct_pkg::OFS_MODE, 16'h0040);
        reg_wr(mct_pkg::OFS_RUN, 16'h0004);
        reg_wr(mct_pkg::OFS_CNT + 8'h02, 16'h0010);
        repeat (4) ENC.step(1'b1);
        rd_chk(mct_pkg::OFS_CNT + 8'h02, 16'h0014);
        repeat (6) ENC.step(1'b0);
        rd_chk(mct_pkg::OFS_CNT + 8'h02, 16'h000e);
        repeat (30) @(posedge clk_i);
        rd_chk(mct_pkg::OFS_CNT + 8'h02, 16'h000e);
        // Underflow sets the wrap flag only with the condition bit clear
        for (int i = 0; i < 2; i++) begin
            reg_wr(mct_pkg::OFS_CLR, 16'h003f);
            reg_wr(mct_pkg::OFS_MODE, i ? 16'h0060 : 16'h0040);
            reg_wr(mct_pkg::OFS_CNT + 8'h02, 16'h0000);
            ENC.step(1'b0);
            rd_chk(mct_pkg::OFS_STAT, i ? 16'h0004 : 16'h0024);
        end
        // Interrupt raised, masked, cleared
        reg_wr(mct_pkg::OFS_IEN, 16'h0004);
        chk({15'h0, irq}, 16'h0001);
        reg_wr(mct_pkg::OFS_IEN, 16'h0020);
        chk({15'h0, irq}, 16'h0000);
        reg_wr(mct_pkg::OFS_IEN, 16'h0004);
        reg_wr(mct_pkg::OFS_CLR, 16'h0004);
        chk({15'h0, irq}, 16'h0000);
        // Clear-on-match in quadrature mode reaches the lockstep fellow
        reg_wr(mct_pkg::OFS_SYNC, 16'h0006);
        reg_wr(mct_pkg::OFS_CLRSEL, 16'h0004);
        reg_wr(mct_pkg::OFS_CMPA + 8'h02, 16'h0010);
        reg_wr(mct_pkg::OFS_CNT + 8'h02, 16'h000f);
        ENC.step(1'b1);
        rd_chk(mct_pkg::OFS_CNT + 8'h02, 16'h0000);
        rd_chk(mct_pkg::OFS_CNT + 8'h01, 16'h0000);
        reg_wr(mct_pkg::OFS_SYNC, 16'h0000);
        // Pulse output on channel 0
        reg_wr(mct_pkg::OFS_MODE, 16'h0001);
        reg_wr(mct_pkg::OFS_CMPA, 16'h0003);
        reg_wr(mct_pkg::OFS_CMPB, 16'h0006);
        reg_wr(mct_pkg::OFS_CNT, 16'h0000);
        chk({15'h0, oe[0]}, 16'h0001);
        chk({15'h0, pulse[0]}, 16'h0000);
        reg_wr(mct_pkg::OFS_RUN, 16'h0001);
        wait_pulse(1'b1);
        wait_pulse(1'b0);
        // Combination field against channel 3 and 4 pulse bits
        reg_wr(mct_pkg::OFS_MODE, 16'h0018);
        for (int k = 0; k < 4; k++) begin
            reg_wr(mct_pkg::OFS_COMB, 16'(k << 4));
            repeat (2) @(posedge clk_i);
            chk({14'h0, oe[4:3]}, k < 2 ? 16'h0003 : 16'h0000);
        end
        // Standby acts as reset
        reg_wr(mct_pkg::OFS_RUN, 16'h001f);
        standby_i <= 1'b1;
        @(posedge clk_i);
        standby_i <= 1'b0;
        @(posedge clk_i);
        rd_chk(mct_pkg::OFS_RUN, 16'h00e0);
        rd_chk(mct_pkg::OFS_MODE, 16'h0080);
        finish_test;
    end
endmodule
